// ==== umpi_pkg.sv ====
// shared constants and types for the uart modem pin interface
package umpi_pkg;

	// ----------------------------------------------------------------
	// line format and timing
	// ----------------------------------------------------------------
	localparam int DATA_BITS = 8;
	localparam int DIV_WIDTH = 16;
	localparam logic [3:0] OVERSAMPLE = 4'hf;
	localparam logic [4:0] START_WAIT = 5'h17;
	localparam logic [3:0] FRAME_BITS = 4'ha;
	localparam int RX_FIFO_DEPTH = 8;

	// ----------------------------------------------------------------
	// modem input bit positions
	// ----------------------------------------------------------------
	localparam int MDM_CTS = 0;
	localparam int MDM_DSR = 1;
	localparam int MDM_DCD = 2;
	localparam int MDM_RI = 3;

	// ----------------------------------------------------------------
	// interrupt identification codes
	// ----------------------------------------------------------------
	localparam logic [3:0] IID_NONE = 4'h1;
	localparam logic [3:0] IID_LINE = 4'h6;
	localparam logic [3:0] IID_RXDATA = 4'h4;
	localparam logic [3:0] IID_TXEMPTY = 4'h2;
	localparam logic [3:0] IID_MODEM = 4'h0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] MDM_RESET = 4'hf;
	localparam logic [9:0] TX_IDLE_SHIFT = 10'h3ff;

	typedef enum logic [1:0] {
		UMPI_RX_IDLE,
		UMPI_RX_START,
		UMPI_RX_DATA,
		UMPI_RX_STOP
	} umpi_rx_state_type;

endpackage : umpi_pkg

// ==== umpi_uart.sv ====
// receive fifo and the uart modem pin interface top level
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------
// Overview of operation
// [RULE1] The serial receive line is synchronised by two flip-flops before the receiver uses it.
// [RULE2] The active-low ring input is reported and its trailing edge sets a sticky flag.
// [RULE3] Transmit data leaves on the serial output line, timed by the bit-rate clock.
// [RULE4] The active-low send request output follows its control bit.
// [RULE5] The active-low terminal ready output follows its control bit.
// [RULE6] The two user outputs drive the inverse of their control bits.
// [RULE7] The high interrupt output is set while an enabled event is pending, with an id code.
// [RULE8] An active-low bit-rate clock derived from the system clock is driven out.
// [RULE9] The receiver ready output is low while received data waits to be read.
// [RULE10] The transmitter ready output is low while the transmit holding slot is free.
// [RULE11] The receive queue empty flag is high while the receive fifo holds nothing.
// [RULE12] The receive queue full flag is high while the receive fifo is full.
// [RULE13] The system clock is divided by the divisor, then by sixteen, to form the bit rate.
// [RULE14] After a low start edge the receiver waits one and a half bits, then samples mid bit.
// [RULE15] Clear-to-send, data-set-ready and carrier inputs are reported with change flags.
// [RULE16] All modem inputs pass two flip-flops before levels or edges are taken from them.

// ----------------------------------------------------------------
// receive fifo
// ----------------------------------------------------------------
module umpi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic empty,
	output logic full
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
	} umpi_fifo_state_type;

	umpi_fifo_state_type s_q, s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_size
		$error("umpi_fifo: depth must be a power of two of at least 2");
	end

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign in_ready = (s_q.count != (AW+1)'(DEPTH));
	assign out_valid = (s_q.count != '0);
	assign empty = (s_q.count == '0);
	assign full = (s_q.count == (AW+1)'(DEPTH));
	assign out_data = mem[s_q.rd_ptr];

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.wr_ptr = s_q.wr_ptr + 1'b1;
		end
		if (pop) begin
			s_d.rd_ptr = s_q.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			s_d.count = s_q.count + 1'b1;
		end else if (pop && !push) begin
			s_d.count = s_q.count - 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[s_q.wr_ptr] <= in_data;
		end
	end
endmodule : umpi_fifo

// ----------------------------------------------------------------
// uart modem pin interface
// ----------------------------------------------------------------
module umpi_uart #(
	parameter int FIFO_DEPTH = umpi_pkg::RX_FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [umpi_pkg::DIV_WIDTH-1:0] divisor,
	input wire logic ctl_send_request,
	input wire logic ctl_terminal_ready,
	input wire logic ctl_user_a,
	input wire logic ctl_user_b,
	input wire logic ie_rx_data,
	input wire logic ie_tx_empty,
	input wire logic ie_line_status,
	input wire logic ie_modem_status,
	input wire logic [7:0] tx_data,
	input wire logic tx_write,
	output logic [7:0] rx_data,
	input wire logic rx_read,
	input wire logic line_status_read,
	input wire logic modem_status_read,
	input wire logic serial_rx_line,
	input wire logic phone_bell_sense,
	input wire logic clear_send_low,
	input wire logic data_set_ready_low,
	input wire logic carrier_detect_low,
	output logic serial_tx_line,
	output logic send_request_low,
	output logic terminal_ready_low,
	output logic user_output_a_low,
	output logic user_output_b_low,
	output logic irq_line,
	output logic [3:0] irq_id,
	output logic bit_rate_clock_low,
	output logic rx_available_low,
	output logic tx_space_low,
	output logic rxfifo_empty,
	output logic rxfifo_full,
	output logic [3:0] modem_state,
	output logic [3:0] modem_delta,
	output logic rx_overrun,
	output logic rx_frame_error
);
	typedef struct packed {
		logic [umpi_pkg::DIV_WIDTH-1:0] div_cnt;
		logic tick;
		logic baud_low;
		logic [7:0] tx_hold;
		logic tx_hold_full;
		logic [9:0] tx_shift;
		logic [3:0] tx_bits;
		logic [3:0] tx_tick;
		logic rx_meta;
		logic rx_s;
		logic [3:0] mdm_meta;
		logic [3:0] mdm_s;
		logic [3:0] mdm_prev;
		logic [3:0] delta;
		umpi_pkg::umpi_rx_state_type rx_st;
		logic [4:0] rx_tick;
		logic [3:0] rx_bits;
		logic [7:0] rx_shift;
		logic rx_pend;
		logic [7:0] rx_pend_data;
		logic overrun;
		logic frame_err;
		logic [3:0] out_pins;
		logic irq;
		logic [3:0] iid;
		logic q_empty;
		logic q_full;
		logic rx_avail_low;
		logic tx_space_low;
	} umpi_state_type;

	umpi_state_type s_q, s_d;
	logic fifo_in_ready, fifo_out_valid, fifo_empty, fifo_full;
	logic [3:0] mdm_pins;

	if (FIFO_DEPTH < 2) begin : g_bad_depth
		$error("umpi_uart: receive fifo depth must be at least 2");
	end

	assign mdm_pins = {phone_bell_sense, carrier_detect_low, data_set_ready_low, clear_send_low};

	umpi_fifo #(
		.WIDTH(umpi_pkg::DATA_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.in_data(s_q.rx_pend_data),
		.in_valid(s_q.rx_pend),
		.in_ready(fifo_in_ready),
		.out_data(rx_data),
		.out_valid(fifo_out_valid),
		.out_ready(rx_read),
		.empty(fifo_empty),
		.full(fifo_full)
	);

	always_comb begin
		s_d = s_q;

		// ----------------------------------------------------------------
		// bit-rate divider, sixteen ticks per bit
		// ----------------------------------------------------------------
		s_d.tick = 1'b0;
		if (divisor == '0) begin
			s_d.div_cnt = '0;
		end else if (s_q.div_cnt >= divisor - 1'b1) begin
			s_d.div_cnt = '0;
			s_d.tick = 1'b1; // [RULE13]
		end else begin
			s_d.div_cnt = s_q.div_cnt + 1'b1;
		end
		s_d.baud_low = !(s_d.div_cnt < (divisor >> 1)); // [RULE8]

		// ----------------------------------------------------------------
		// synchronisers
		// ----------------------------------------------------------------
		s_d.rx_meta = serial_rx_line;
		s_d.rx_s = s_q.rx_meta; // [RULE1]
		s_d.mdm_meta = mdm_pins;
		s_d.mdm_s = s_q.mdm_meta; // [RULE16]
		s_d.mdm_prev = s_q.mdm_s;

		// ----------------------------------------------------------------
		// modem status and change flags, set beats clear
		// ----------------------------------------------------------------
		if (modem_status_read) begin
			s_d.delta = '0;
		end
		for (int i = 0; i < 3; i++) begin
			if (s_q.mdm_s[i] != s_q.mdm_prev[i]) begin
				s_d.delta[i] = 1'b1; // [RULE15]
			end
		end
		if (s_q.mdm_s[umpi_pkg::MDM_RI] && !s_q.mdm_prev[umpi_pkg::MDM_RI]) begin
			s_d.delta[umpi_pkg::MDM_RI] = 1'b1; // [RULE2]
		end

		// ----------------------------------------------------------------
		// transmitter
		// ----------------------------------------------------------------
		if (tx_write && !s_q.tx_hold_full) begin
			s_d.tx_hold = tx_data;
			s_d.tx_hold_full = 1'b1;
		end
		if (s_q.tick) begin
			if (s_q.tx_bits == '0) begin
				if (s_q.tx_hold_full) begin
					s_d.tx_shift = {1'b1, s_q.tx_hold, 1'b0};
					s_d.tx_bits = umpi_pkg::FRAME_BITS;
					s_d.tx_tick = '0;
					s_d.tx_hold_full = 1'b0;
				end
			end else if (s_q.tx_tick == umpi_pkg::OVERSAMPLE) begin
				s_d.tx_tick = '0;
				s_d.tx_shift = {1'b1, s_q.tx_shift[9:1]}; // [RULE3]
				s_d.tx_bits = s_q.tx_bits - 1'b1;
			end else begin
				s_d.tx_tick = s_q.tx_tick + 1'b1;
			end
		end

		// ----------------------------------------------------------------
		// receiver
		// ----------------------------------------------------------------
		if (s_q.rx_pend && fifo_in_ready) begin
			s_d.rx_pend = 1'b0;
		end
		if (line_status_read) begin
			s_d.overrun = 1'b0;
			s_d.frame_err = 1'b0;
		end
		if (s_q.tick) begin
			case (s_q.rx_st)
				umpi_pkg::UMPI_RX_IDLE: begin
					if (!s_q.rx_s) begin
						s_d.rx_st = umpi_pkg::UMPI_RX_START;
						s_d.rx_tick = '0;
					end
				end
				umpi_pkg::UMPI_RX_START: begin
					if (s_q.rx_tick == umpi_pkg::START_WAIT) begin
						s_d.rx_shift = {s_q.rx_s, s_q.rx_shift[7:1]}; // [RULE14]
						s_d.rx_bits = 4'h1;
						s_d.rx_tick = '0;
						s_d.rx_st = umpi_pkg::UMPI_RX_DATA;
					end else begin
						s_d.rx_tick = s_q.rx_tick + 1'b1;
					end
				end
				umpi_pkg::UMPI_RX_DATA: begin
					if (s_q.rx_tick == {1'b0, umpi_pkg::OVERSAMPLE}) begin
						s_d.rx_tick = '0;
						if (s_q.rx_bits == 4'(umpi_pkg::DATA_BITS)) begin
							s_d.rx_st = umpi_pkg::UMPI_RX_IDLE;
							if (!s_q.rx_s) begin
								s_d.frame_err = 1'b1;
							end else if (s_d.rx_pend) begin
								s_d.overrun = 1'b1;
							end else begin
								s_d.rx_pend = 1'b1;
								s_d.rx_pend_data = s_q.rx_shift;
							end
						end else begin
							s_d.rx_shift = {s_q.rx_s, s_q.rx_shift[7:1]};
							s_d.rx_bits = s_q.rx_bits + 1'b1;
						end
					end else begin
						s_d.rx_tick = s_q.rx_tick + 1'b1;
					end
				end
				default: begin
					s_d.rx_st = umpi_pkg::UMPI_RX_IDLE;
				end
			endcase
		end

		// ----------------------------------------------------------------
		// pins and flags
		// ----------------------------------------------------------------
		s_d.out_pins = {!ctl_user_b, !ctl_user_a, !ctl_terminal_ready, !ctl_send_request}; // [RULE6]
		s_d.q_empty = fifo_empty; // [RULE11]
		s_d.q_full = fifo_full; // [RULE12]
		s_d.rx_avail_low = !fifo_out_valid; // [RULE9]
		s_d.tx_space_low = s_d.tx_hold_full; // [RULE10]

		s_d.iid = umpi_pkg::IID_NONE;
		if (ie_line_status && (s_q.overrun || s_q.frame_err)) begin
			s_d.iid = umpi_pkg::IID_LINE;
		end else if (ie_rx_data && fifo_out_valid) begin
			s_d.iid = umpi_pkg::IID_RXDATA;
		end else if (ie_tx_empty && !s_q.tx_hold_full) begin
			s_d.iid = umpi_pkg::IID_TXEMPTY;
		end else if (ie_modem_status && (s_q.delta != '0)) begin
			s_d.iid = umpi_pkg::IID_MODEM;
		end
		s_d.irq = (s_d.iid != umpi_pkg::IID_NONE); // [RULE7]
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.baud_low <= 1'b1;
			s_q.tx_shift <= umpi_pkg::TX_IDLE_SHIFT;
			s_q.rx_meta <= 1'b1;
			s_q.rx_s <= 1'b1;
			s_q.mdm_meta <= umpi_pkg::MDM_RESET;
			s_q.mdm_s <= umpi_pkg::MDM_RESET;
			s_q.mdm_prev <= umpi_pkg::MDM_RESET;
			s_q.out_pins <= 4'hf;
			s_q.iid <= umpi_pkg::IID_NONE;
			s_q.q_empty <= 1'b1;
			s_q.rx_avail_low <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign serial_tx_line = s_q.tx_shift[0]; // [RULE3]
	assign send_request_low = s_q.out_pins[0]; // [RULE4]
	assign terminal_ready_low = s_q.out_pins[1]; // [RULE5]
	assign user_output_a_low = s_q.out_pins[2];
	assign user_output_b_low = s_q.out_pins[3];
	assign irq_line = s_q.irq;
	assign irq_id = s_q.iid;
	assign bit_rate_clock_low = s_q.baud_low;
	assign rx_available_low = s_q.rx_avail_low;
	assign tx_space_low = s_q.tx_space_low;
	assign rxfifo_empty = s_q.q_empty;
	assign rxfifo_full = s_q.q_full;
	assign modem_state = ~s_q.mdm_s;
	assign modem_delta = s_q.delta;
	assign rx_overrun = s_q.overrun;
	assign rx_frame_error = s_q.frame_err;
endmodule : umpi_uart

// ==== umpi_uart_asserts.sv ====
// port assertions for the uart modem pin interface
`timescale 1ns/10ps
module umpi_uart_asserts #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [umpi_pkg::DIV_WIDTH-1:0] divisor,
	input wire logic ctl_send_request,
	input wire logic ctl_terminal_ready,
	input wire logic ctl_user_a,
	input wire logic ctl_user_b,
	input wire logic ie_rx_data,
	input wire logic ie_tx_empty,
	input wire logic ie_line_status,
	input wire logic ie_modem_status,
	input wire logic phone_bell_sense,
	input wire logic clear_send_low,
	input wire logic serial_tx_line,
	input wire logic send_request_low,
	input wire logic terminal_ready_low,
	input wire logic user_output_a_low,
	input wire logic user_output_b_low,
	input wire logic irq_line,
	input wire logic bit_rate_clock_low,
	input wire logic rx_available_low,
	input wire logic rxfifo_empty,
	input wire logic rxfifo_full,
	input wire logic [3:0] modem_state,
	input wire logic [3:0] modem_delta
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_rts_dtr;
		$past(nrst) |-> {send_request_low, terminal_ready_low} ==
			~{$past(ctl_send_request), $past(ctl_terminal_ready)};
	endproperty
	a_rts_dtr: assert property (p_rts_dtr) else $error("rts dtr pins");
	property p_user;
		$past(nrst) |-> {user_output_a_low, user_output_b_low} ==
			~{$past(ctl_user_a), $past(ctl_user_b)};
	endproperty
	a_user: assert property (p_user) else $error("user pins");
	sequence s_no_enable;
		!(ie_rx_data || ie_tx_empty || ie_line_status || ie_modem_status);
	endsequence
	property p_irq_off; s_no_enable [*2] |-> !irq_line; endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq without enable");
	property p_flags; !(rxfifo_empty && rxfifo_full); endproperty
	a_flags: assert property (p_flags) else $error("empty and full");
	property p_avail; rxfifo_empty |-> rx_available_low; endproperty
	a_avail: assert property (p_avail) else $error("avail while empty");
	property p_cts;
		$fell(clear_send_low) && !modem_state[0] |-> ##1 !modem_state[0] ##[1:3] modem_state[0];
	endproperty
	a_cts: assert property (p_cts) else $error("cts sync timing");
	property p_ring; $rose(phone_bell_sense) |-> ##[2:4] modem_delta[3]; endproperty
	a_ring: assert property (p_ring) else $error("ring edge flag");
	property p_tick;
		(divisor == 16'h4) [*8] ##0 $fell(bit_rate_clock_low) |-> ##4 $fell(bit_rate_clock_low);
	endproperty
	a_tick: assert property (p_tick) else $error("tick period");
	c_full: cover property (rxfifo_full);
	c_irq: cover property (irq_line);
	c_tx: cover property ($fell(serial_tx_line));
endmodule : umpi_uart_asserts

bind umpi_uart umpi_uart_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) umpi_uart_asserts_inst (.*);

// ==== umpi_line_model.sv ====
// serial device on the line side: sends and captures 8n1 frames
`timescale 1ns/10ps
module umpi_line_model (
	input wire logic clk_sys,
	input wire logic [umpi_pkg::DIV_WIDTH-1:0] divisor,
	input wire logic serial_tx_line,
	output logic serial_rx_line
);
	logic [7:0] got_q[$];
	initial serial_rx_line = 1'b1;
	task automatic send_byte(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			serial_rx_line <= f[i];
			repeat (16 * divisor) @(posedge clk_sys);
		end
		// a low stop bit is followed by twelve idle bits
		if (!stop) begin
			serial_rx_line <= 1'b1;
			repeat (192 * divisor) @(posedge clk_sys);
		end
	endtask : send_byte
	// sample mid bit after the start edge
	initial begin : capture
		logic [7:0] b;
		forever begin
			@(negedge serial_tx_line);
			repeat (8 * divisor) @(posedge clk_sys);
			for (int i = 0; i < 8; i++) begin
				repeat (16 * divisor) @(posedge clk_sys);
				b[i] = serial_tx_line;
			end
			repeat (16 * divisor) @(posedge clk_sys);
			if (serial_tx_line === 1'b1) got_q.push_back(b);
		end
	end
endmodule : umpi_line_model

// ==== test_uart_modem_pin_interface.sv ====
// self-checking bench for the uart modem pin interface
`timescale 1ns/10ps
module test_uart_modem_pin_interface;
	logic clk_sys, nrst, tx_write, rx_read, ls_read, ms_read;
	logic [15:0] divisor;
	logic [3:0] ctl, ie, mdm_low;
	logic [7:0] tx_data, b;
	wire logic [3:0] pins_low, irq_id, mstate, mdelta;
	wire logic [7:0] rx_data;
	wire logic rx_line, tx_line, irq, brc_low, rxa_low, txs_low, empty, full, ovr, ferr;
	logic [7:0] exp_q[$];
	int fails, comparisons, n;
	umpi_uart umpi_uart_inst (.clk_sys, .nrst, .divisor, .ctl_send_request(ctl[0]),
		.ctl_terminal_ready(ctl[1]), .ctl_user_a(ctl[2]), .ctl_user_b(ctl[3]),
		.ie_rx_data(ie[0]), .ie_tx_empty(ie[1]), .ie_line_status(ie[2]),
		.ie_modem_status(ie[3]), .tx_data, .tx_write, .rx_data, .rx_read,
		.line_status_read(ls_read), .modem_status_read(ms_read), .serial_rx_line(rx_line),
		.phone_bell_sense(mdm_low[3]), .clear_send_low(mdm_low[0]),
		.data_set_ready_low(mdm_low[1]), .carrier_detect_low(mdm_low[2]),
		.serial_tx_line(tx_line), .send_request_low(pins_low[0]),
		.terminal_ready_low(pins_low[1]), .user_output_a_low(pins_low[2]),
		.user_output_b_low(pins_low[3]), .irq_line(irq), .irq_id, .bit_rate_clock_low(brc_low),
		.rx_available_low(rxa_low), .tx_space_low(txs_low), .rxfifo_empty(empty),
		.rxfifo_full(full), .modem_state(mstate), .modem_delta(mdelta), .rx_overrun(ovr),
		.rx_frame_error(ferr));
	umpi_line_model umpi_line_model_inst (.clk_sys, .divisor, .serial_tx_line(tx_line),
		.serial_rx_line(rx_line));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic step(input int k);
		repeat (k) @(posedge clk_sys);
		#2;
	endtask : step
	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
		step(1);
	endtask : pulse
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic tally_and_finish;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic timeout_if(input logic c);
		if (c) begin
			fails++;
			$display("CHECK FAILED wait expected done seen timeout");
			tally_and_finish();
		end
	endtask : timeout_if
	task automatic count_ticks(output int c);
		logic p;
		c = 0;
		p = brc_low;
		repeat (40) begin
			step(1);
			c += int'(p === 1'b1 && brc_low === 1'b0);
			p = brc_low;
		end
	endtask : count_ticks
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{nrst, tx_write, rx_read, ls_read, ms_read} = 5'h0;
		{divisor, ctl, ie, mdm_low, tx_data} = {16'h0, 4'h0, 4'h0, 4'hf, 8'h0};
		fails = 0;
		comparisons = 0;
		n = $urandom(32'hd136);
		step(3);
		cmp("reset pins", 8'h0f, {4'h0, pins_low});
		cmp("reset fifo", 8'h01, {full, empty});
		nrst = 1'b1;
		for (int i = 0; i < 16; i++) begin
			ctl = 4'(i);
			step(2);
			cmp("ctl pins", {4'h0, ~ctl}, {4'h0, pins_low});
		end
		$display("test control pins done");
		step(6);
		count_ticks(n);
		cmp("ticks off", 8'h0, 8'(n));
		divisor = 16'h4;
		step(8);
		count_ticks(n);
		cmp("ticks", 8'd10, 8'(n));
		$display("test bit clock done");
		cmp("tx space", 8'h0, {7'h0, txs_low});
		for (int i = 0; i < 3; i++) begin
			for (n = 0; n < 2000 && txs_low !== 1'b0; n++) step(1);
			timeout_if(n == 2000);
			tx_data = 8'($urandom);
			exp_q.push_back(tx_data);
			pulse(tx_write);
			step(1);
		end
		for (n = 0; n < 3000 && umpi_line_model_inst.got_q.size() < 3; n++) step(1);
		timeout_if(n == 3000);
		foreach (exp_q[i]) cmp("tx byte", exp_q[i], umpi_line_model_inst.got_q[i]);
		exp_q = {};
		$display("test transmit done");
		// eight fill the fifo, the ninth waits pending, the tenth overruns
		for (int i = 0; i < 10; i++) begin
			b = 8'($urandom);
			if (i < 9) exp_q.push_back(b);
			umpi_line_model_inst.send_byte(b, 1'b1);
		end
		step(4);
		cmp("full ovr", 8'h06, {ovr, full, empty});
		ie = 4'h1;
		step(3);
		cmp("irq rx", {3'h0, 1'b1, umpi_pkg::IID_RXDATA}, {3'h0, irq, irq_id});
		ie = 4'h5;
		step(3);
		cmp("irq line", {3'h0, 1'b1, umpi_pkg::IID_LINE}, {3'h0, irq, irq_id});
		pulse(ls_read);
		step(2);
		cmp("irq rx", {3'h0, 1'b1, umpi_pkg::IID_RXDATA}, {3'h0, irq, irq_id});
		ie = 4'h0;
		step(3);
		cmp("irq none", {3'h0, 1'b0, umpi_pkg::IID_NONE}, {3'h0, irq, irq_id});
		while (exp_q.size() > 0) begin
			cmp("rx avail", 8'h0, {7'h0, rxa_low});
			cmp("rx byte", exp_q.pop_front(), rx_data);
			pulse(rx_read);
		end
		cmp("drained", 8'h03, {full, empty, rxa_low});
		ie = 4'h2;
		step(3);
		cmp("irq tx", {3'h0, 1'b1, umpi_pkg::IID_TXEMPTY}, {3'h0, irq, irq_id});
		ie = 4'h0;
		// low stop bit: byte dropped, the low tail reads as an all-ones frame
		b = 8'($urandom);
		umpi_line_model_inst.send_byte(b, 1'b0);
		step(4);
		cmp("frame err", 8'h02, {6'h0, ferr, empty});
		cmp("break byte", 8'hff, rx_data);
		pulse(rx_read);
		pulse(ls_read);
		cmp("frame clear", 8'h01, {6'h0, ferr, empty});
		$display("test receive done");
		for (int i = 0; i < 4; i++) begin
			mdm_low[i] = 1'b0;
			step(5);
			cmp("modem state", 8'(1 << i), {4'h0, mstate});
			cmp("modem delta", (i < 3) ? 8'(1 << i) : 8'h0, {4'h0, mdelta});
			mdm_low[i] = 1'b1;
			step(5);
			ie = 4'h8;
			step(3);
			cmp("irq modem", {3'h0, 1'b1, umpi_pkg::IID_MODEM}, {3'h0, irq, irq_id});
			ie = 4'h0;
			pulse(ms_read);
			step(1);
			cmp("delta clear", 8'h0, {4'h0, mdelta});
		end
		$display("test modem inputs done");
		tally_and_finish();
	end
endmodule : test_uart_modem_pin_interface
